//--- common/asr_params.svh
/*
  Constants of the asynchronous serial receiver: special-function addresses,
  bank numbers, field positions, reset values and receive timing counts.
  Assumes it is included by its bare name wherever these macros are used.
*/
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH

// special-function addresses and banking
`define ASR_ADDR_BANK_SELECT 8'h0f
`define ASR_BANKED_LO 8'h10
`define ASR_BANKED_HI 8'h17
`define ASR_ADDR_RX_STATUS 8'h13
`define ASR_ADDR_RX_DATA 8'h14
`define ASR_ADDR_TX_STATUS 8'h15
`define ASR_ADDR_IRQ_FLAGS 8'h16
`define ASR_ADDR_IRQ_EN 8'h17
`define ASR_ADDR_BAUD 8'h17
`define ASR_BANK_SERIAL 4'h0
`define ASR_BANK_IRQ 4'h1

// receive status and control fields
`define ASR_BIT_PORT_ENABLE 7
`define ASR_BIT_NINE_BIT 6
`define ASR_BIT_SINGLE_RX 5
`define ASR_BIT_CONT_RX 4
`define ASR_BIT_FRAME_ERR 2
`define ASR_BIT_OVERRUN 1
`define ASR_BIT_NINTH_DATA 0

// transmit status and control fields
`define ASR_BIT_CSRC 7
`define ASR_BIT_TX9 6
`define ASR_BIT_TXEN 5
`define ASR_BIT_SYNC 4
`define ASR_BIT_TRMT 1
`define ASR_BIT_TX9D 0

// interrupt flag and enable fields
`define ASR_BIT_TX_EMPTY 1
`define ASR_BIT_RX_FULL 0
`define ASR_BIT_RX_FULL_IE 0

// reset values
`define ASR_RST_RX_STATUS 8'h00
`define ASR_RST_TX_STATUS 8'h02
`define ASR_RST_IRQ_EN 8'h00
`define ASR_RST_BAUD 8'h00
`define ASR_RST_BANK 8'h00

// receive timing in baud ticks, and last data bit index per character length
`define ASR_OVERSAMPLE_LAST 4'hf
`define ASR_SAMPLE_PHASE 4'h7
`define ASR_LAST_BIT_8 4'h7
`define ASR_LAST_BIT_9 4'h8

// receive buffer shape
`define ASR_FIFO_WIDTH 10
`define ASR_FIFO_DEPTH 8

`endif

//--- common/asr_pkg.sv
/*
  Types of the asynchronous serial receiver: receive states, register
  selects and the registered state of the top module.
  Assumes asr_params.svh is on the include path.
*/
package asr_pkg;

	typedef enum logic [1:0] {
		ASR_IDLE,
		ASR_START,
		ASR_DATA,
		ASR_STOP
	} asr_rx_state_t;

	typedef enum logic [2:0] {
		ASR_SEL_NONE,
		ASR_SEL_RX_STATUS,
		ASR_SEL_RX_DATA,
		ASR_SEL_TX_STATUS,
		ASR_SEL_IRQ_FLAGS,
		ASR_SEL_IRQ_EN,
		ASR_SEL_BAUD,
		ASR_SEL_BANK
	} asr_sel_t;

	typedef struct packed {
		asr_rx_state_t st;
		logic [7:0] div_cnt;
		logic [3:0] phase;
		logic [3:0] bit_idx;
		logic [8:0] shreg;
		logic serial_port_enable;
		logic nine_bit_receive_select;
		logic single_receive_enable;
		logic continuous_receive_enable;
		logic overrun_error_flag;
		logic csrc;
		logic tx9;
		logic txen;
		logic sync;
		logic tx9d;
		logic [7:0] baud;
		logic [7:0] irq_en;
		logic [7:0] bank;
		logic [7:0] rdata;
		logic irq;
		logic pins_active;
		logic ck_out;
		logic ck_oe_n;
		logic ck_prev;
	} asr_regs_t;

endpackage

//--- logic/asr_fifo.sv
/*
  Receive buffer: a flop-based FIFO with valid and ready on both sides.
  Assumes a single clock, synchronous active-high reset, and DEPTH above one.
*/
module asr_fifo
	import asr_pkg::*;
#(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [CW-1:0] count;
	} asr_fifo_state_t;

	asr_fifo_state_t cur;
	asr_fifo_state_t next_cur;
	logic push;
	logic pop;

	assign in_ready = (cur.count != CW'(DEPTH));
	assign out_valid = (cur.count != '0);
	assign out_data = cur.mem[cur.rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		next_cur = cur;
		if (push) begin
			next_cur.mem[cur.wr_ptr] = in_data;
			next_cur.wr_ptr = (cur.wr_ptr == AW'(DEPTH - 1)) ? '0 : cur.wr_ptr + 1'b1;
		end
		if (pop) begin
			next_cur.rd_ptr = (cur.rd_ptr == AW'(DEPTH - 1)) ? '0 : cur.rd_ptr + 1'b1;
		end
		// simultaneous push and pop leave the count unchanged
		if (push && !pop) begin
			next_cur.count = cur.count + 1'b1;
		end else if (pop && !push) begin
			next_cur.count = cur.count - 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

endmodule

//--- logic/asr_receiver.sv
/*
  Serial port receiver with its banked special-function registers: bank
  select, receive status and control, receive data, transmit status and
  control (mode bits only), interrupt flags, interrupt enables, baud divisor.
  Assumes a synchronous core bus that presents address and strobes for one
  cycle, and a receive pin already synchronous to sys_clk.

  // Function
  // - port enable switches pins to serial function
  // - nine-bit select sets character length
  // - single receive takes one byte, sync master
  // - continuous receive enables; overrides single receive
  // - status bit three always reads zero
  // - framing error tracks character, updated by data read
  // - overrun cleared only by clearing continuous receive
  // - ninth received bit held in status
  // - receive full flag; irq needs enable
  // - data read returns low eight bits
  // - disabling reception resets receive logic
  // - addresses 10h-17h banked by low nibble
  // - unimplemented bank reads zero, drops writes
  // - vector entry does not clear receive flag
*/
`include "asr_params.svh"

module asr_receiver
	import asr_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// special-function register port
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	// interrupt request toward the peripheral vector
	output logic rx_irq,
	// serial pins
	input wire logic serial_rx_data_pin,
	input wire logic serial_tx_clock_pin_in,
	output logic serial_tx_clock_pin_out,
	output logic serial_tx_clock_pin_oe_n,
	output logic serial_pins_active
);

	asr_regs_t cur;
	asr_regs_t next_cur;

	// receive buffer signals
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [`ASR_FIFO_WIDTH-1:0] fifo_in_data;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [`ASR_FIFO_WIDTH-1:0] fifo_out_data;

	// decode of the banked register space, shared by read and write
	function automatic asr_sel_t decode(input logic [7:0] addr, input logic [3:0] bank);
		asr_sel_t sel;
		sel = ASR_SEL_NONE;
		if (addr == `ASR_ADDR_BANK_SELECT) begin
			sel = ASR_SEL_BANK;
		end else if (addr < `ASR_BANKED_LO || addr > `ASR_BANKED_HI) begin
			sel = ASR_SEL_NONE;
		end else if (bank == `ASR_BANK_SERIAL && addr == `ASR_ADDR_RX_STATUS) begin
			sel = ASR_SEL_RX_STATUS;
		end else if (bank == `ASR_BANK_SERIAL && addr == `ASR_ADDR_RX_DATA) begin
			sel = ASR_SEL_RX_DATA;
		end else if (bank == `ASR_BANK_SERIAL && addr == `ASR_ADDR_TX_STATUS) begin
			sel = ASR_SEL_TX_STATUS;
		end else if (bank == `ASR_BANK_SERIAL && addr == `ASR_ADDR_BAUD) begin
			sel = ASR_SEL_BAUD;
		end else if (bank == `ASR_BANK_IRQ && addr == `ASR_ADDR_IRQ_FLAGS) begin
			sel = ASR_SEL_IRQ_FLAGS;
		end else if (bank == `ASR_BANK_IRQ && addr == `ASR_ADDR_IRQ_EN) begin
			sel = ASR_SEL_IRQ_EN;
		end else begin
			sel = ASR_SEL_NONE;
		end
		return sel;
	endfunction

	asr_sel_t sel;
	logic rd_rx_data;
	logic wr_rx_status;
	logic sync_master;
	logic sync_slave;
	logic rx_on;
	logic tick;
	logic ck_rise;
	logic sample_now;
	logic bit_end;
	logic [3:0] last_bit;
	logic [8:0] cur_bits;
	logic head_framing_error_flag;
	logic head_ninth;
	logic [7:0] head_data;
	logic receive_full;

	assign sel = decode(sfr_addr, cur.bank[3:0]);
	assign rd_rx_data = sfr_rd && (sel == ASR_SEL_RX_DATA);
	assign wr_rx_status = sfr_wr && (sel == ASR_SEL_RX_STATUS);

	// head of the buffer: status bits follow the character about to be read
	assign head_framing_error_flag = fifo_out_valid && fifo_out_data[9];
	assign head_ninth = fifo_out_valid && fifo_out_data[8];
	assign head_data = fifo_out_valid ? fifo_out_data[7:0] : 8'h00;
	// flag follows buffer content; nothing but a data read drains it
	assign receive_full = fifo_out_valid;
	// a data read advances to the next character
	assign fifo_out_ready = rd_rx_data;

	assign sync_master = cur.sync && cur.csrc;
	assign sync_slave = cur.sync && !cur.csrc;
	// single receive only counts in sync master mode
	assign rx_on = cur.serial_port_enable && !cur.overrun_error_flag &&
		(sync_master ? (cur.continuous_receive_enable || cur.single_receive_enable) :
		cur.continuous_receive_enable);

	assign tick = (cur.div_cnt == 8'h00);
	assign ck_rise = serial_tx_clock_pin_in && !cur.ck_prev;
	assign sample_now = sync_slave ? ck_rise : (tick && cur.phase == `ASR_SAMPLE_PHASE);
	assign bit_end = sync_slave ? ck_rise : (tick && cur.phase == `ASR_OVERSAMPLE_LAST);
	assign last_bit = cur.nine_bit_receive_select ? `ASR_LAST_BIT_9 : `ASR_LAST_BIT_8;

	// shift register with the bit being sampled this cycle folded in
	always_comb begin
		cur_bits = cur.shreg;
		if (sample_now && cur.st == ASR_DATA) begin
			cur_bits[cur.bit_idx] = serial_rx_data_pin;
		end
	end

	always_comb begin
		next_cur = cur;
		fifo_in_valid = 1'b0;
		fifo_in_data = '0;

		// register writes; dropped when no register answers
		if (sfr_wr) begin
			case (sel)
				ASR_SEL_BANK: begin
					next_cur.bank = sfr_wdata;
				end
				ASR_SEL_RX_STATUS: begin
					next_cur.serial_port_enable = sfr_wdata[`ASR_BIT_PORT_ENABLE];
					next_cur.nine_bit_receive_select = sfr_wdata[`ASR_BIT_NINE_BIT];
					next_cur.single_receive_enable = sfr_wdata[`ASR_BIT_SINGLE_RX];
					next_cur.continuous_receive_enable = sfr_wdata[`ASR_BIT_CONT_RX];
				end
				ASR_SEL_TX_STATUS: begin
					next_cur.csrc = sfr_wdata[`ASR_BIT_CSRC];
					next_cur.tx9 = sfr_wdata[`ASR_BIT_TX9];
					next_cur.txen = sfr_wdata[`ASR_BIT_TXEN];
					next_cur.sync = sfr_wdata[`ASR_BIT_SYNC];
					next_cur.tx9d = sfr_wdata[`ASR_BIT_TX9D];
				end
				ASR_SEL_IRQ_EN: begin
					next_cur.irq_en = sfr_wdata;
				end
				ASR_SEL_BAUD: begin
					next_cur.baud = sfr_wdata;
				end
				default: begin
					next_cur.bank = cur.bank;
				end
			endcase
		end

		// overrun clears only on a falling continuous-receive enable
		if (wr_rx_status && cur.continuous_receive_enable &&
			!sfr_wdata[`ASR_BIT_CONT_RX]) begin
			next_cur.overrun_error_flag = 1'b0;
		end

		// edge memory for the external clock in slave mode
		next_cur.ck_prev = serial_tx_clock_pin_in;

		if (!rx_on) begin
			// disabled or halted: engine back to its starting point
			next_cur.st = ASR_IDLE;
			next_cur.div_cnt = cur.baud;
			next_cur.phase = 4'h0;
			next_cur.bit_idx = 4'h0;
			next_cur.shreg = 9'h000;
		end else begin
			// baud divisor: one tick every divisor+1 cycles
			if (tick) begin
				next_cur.div_cnt = cur.baud;
				next_cur.phase = cur.phase + 4'h1;
			end else begin
				next_cur.div_cnt = cur.div_cnt - 8'h01;
			end

			case (cur.st)
				ASR_IDLE: begin
					next_cur.div_cnt = cur.baud;
					next_cur.phase = 4'h0;
					next_cur.bit_idx = 4'h0;
					next_cur.shreg = 9'h000;
					if (cur.sync) begin
						// clocked modes carry no start bit
						next_cur.st = ASR_DATA;
					end else if (!serial_rx_data_pin) begin
						next_cur.st = ASR_START;
					end
				end
				ASR_START: begin
					// a start bit gone high at mid-bit was noise
					if (sample_now && serial_rx_data_pin) begin
						next_cur.st = ASR_IDLE;
					end else if (bit_end) begin
						next_cur.st = ASR_DATA;
						next_cur.bit_idx = 4'h0;
					end
				end
				ASR_DATA: begin
					next_cur.shreg = cur_bits;
					if (bit_end) begin
						if (cur.bit_idx != last_bit) begin
							next_cur.bit_idx = cur.bit_idx + 4'h1;
						end else if (cur.sync) begin
							// clocked character complete
							next_cur.st = ASR_IDLE;
							fifo_in_valid = 1'b1;
							fifo_in_data = {1'b0, cur.nine_bit_receive_select && cur_bits[8],
								cur_bits[7:0]};
							if (sync_master && !cur.continuous_receive_enable) begin
								next_cur.single_receive_enable = 1'b0;
							end
						end else begin
							next_cur.st = ASR_STOP;
						end
					end
				end
				ASR_STOP: begin
					// stop sampled at mid-bit, then idle to catch the next start
					if (sample_now) begin
						next_cur.st = ASR_IDLE;
						fifo_in_valid = 1'b1;
						fifo_in_data = {!serial_rx_data_pin,
							cur.nine_bit_receive_select && cur.shreg[8],
							cur.shreg[7:0]};
					end
				end
				default: begin
					next_cur.st = ASR_IDLE;
				end
			endcase

			// full buffer: character lost, reception halts until cleared
			if (fifo_in_valid && !fifo_in_ready) begin
				next_cur.overrun_error_flag = 1'b1;
				next_cur.st = ASR_IDLE;
			end
		end

		// software set of single receive wins over the hardware clear
		if (wr_rx_status) begin
			next_cur.single_receive_enable = sfr_wdata[`ASR_BIT_SINGLE_RX];
		end

		// registered read data, valid the cycle after the strobe
		if (sfr_rd) begin
			case (sel)
				ASR_SEL_BANK: begin
					next_cur.rdata = cur.bank;
				end
				ASR_SEL_RX_STATUS: begin
					next_cur.rdata = {cur.serial_port_enable, cur.nine_bit_receive_select,
						cur.single_receive_enable, cur.continuous_receive_enable, 1'b0,
						head_framing_error_flag, cur.overrun_error_flag,
						head_ninth};
				end
				ASR_SEL_RX_DATA: begin
					next_cur.rdata = head_data;
				end
				ASR_SEL_TX_STATUS: begin
					// no transmitter here: shift register always reads empty
					next_cur.rdata = {cur.csrc, cur.tx9, cur.txen, cur.sync, 2'b00, 1'b1,
						cur.tx9d};
				end
				ASR_SEL_IRQ_FLAGS: begin
					next_cur.rdata = {6'h00, 1'b1, receive_full};
				end
				ASR_SEL_IRQ_EN: begin
					next_cur.rdata = cur.irq_en;
				end
				ASR_SEL_BAUD: begin
					next_cur.rdata = cur.baud;
				end
				default: begin
					next_cur.rdata = 8'h00;
				end
			endcase
		end

		// interrupt request gated by the receive-full interrupt enable bit
		next_cur.irq = receive_full && cur.irq_en[`ASR_BIT_RX_FULL_IE];
		next_cur.pins_active = cur.serial_port_enable;
		// clock pin is driven only as a sync master with the port on
		next_cur.ck_oe_n = !(cur.serial_port_enable && sync_master);
		next_cur.ck_out = sync_master && (next_cur.st == ASR_DATA) && next_cur.phase[3];
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cur <= '0;
			cur.st <= ASR_IDLE;
			cur.serial_port_enable <= 1'(`ASR_RST_RX_STATUS >> `ASR_BIT_PORT_ENABLE);
			cur.baud <= `ASR_RST_BAUD;
			cur.irq_en <= `ASR_RST_IRQ_EN;
			cur.bank <= `ASR_RST_BANK;
			cur.ck_oe_n <= 1'b1;
		end else begin
			cur <= next_cur;
		end
	end

	asr_fifo #(
		.WIDTH(`ASR_FIFO_WIDTH),
		.DEPTH(`ASR_FIFO_DEPTH)
	) i_asr_fifo (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	assign sfr_rdata = cur.rdata;
	assign rx_irq = cur.irq;
	assign serial_pins_active = cur.pins_active;
	assign serial_tx_clock_pin_out = cur.ck_out;
	assign serial_tx_clock_pin_oe_n = cur.ck_oe_n;

endmodule

//--- testbench/asr_receiver_props.sv
/*
  Checker of the receiver's register port, interrupt and pins.
  Assumes a bind onto asr_receiver and writes that last one strobe cycle.
*/
module asr_receiver_props (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	// interrupt and pins
	input wire logic rx_irq,
	input wire logic serial_rx_data_pin,
	input wire logic serial_tx_clock_pin_in,
	input wire logic serial_tx_clock_pin_out,
	input wire logic serial_tx_clock_pin_oe_n,
	input wire logic serial_pins_active
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] bank_h;
	logic receive_full_irq_enable_h;
	// shadow writes so the checks know the bank
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bank_h <= 8'h00;
			receive_full_irq_enable_h <= 1'b0;
		end else if (sfr_wr) begin
			if (sfr_addr == 8'h0f)
				bank_h <= sfr_wdata;
			if (sfr_addr == 8'h17 && bank_h[3:0] == 4'h1)
				receive_full_irq_enable_h <= sfr_wdata[0];
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_wr(a);
		sfr_wr && sfr_addr == a && bank_h[3:0] == 4'h0;
	endsequence
	sequence s_rd(a, b);
		sfr_rd && sfr_addr == a && bank_h[3:0] == b;
	endsequence
	a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	a_reset_quiet: assert property (disable iff (1'b0) rst |=> sfr_rdata == 8'h00
		&& !rx_irq && serial_tx_clock_pin_oe_n && !serial_pins_active)
		else $error("outputs not quiet after reset");
	a_pins_on: assert property (s_wr(8'h13) ##0 sfr_wdata[7] |-> ##[1:2] serial_pins_active)
		else $error("pins not switched on");
	a_pins_off: assert property (s_wr(8'h13) ##0 !sfr_wdata[7] |-> ##[1:2] !serial_pins_active)
		else $error("pins not released");
	a_unmapped_zero: assert property (sfr_rd && sfr_addr >= 8'h10 && sfr_addr <= 8'h17
		&& bank_h[3:1] != 3'h0 |=> sfr_rdata == 8'h00)
		else $error("empty bank read not zero");
	a_status_bit3: assert property (s_rd(8'h13, 4'h0) |=> !sfr_rdata[3])
		else $error("status bit three set");
	a_flags_fixed: assert property (s_rd(8'h16, 4'h1) |=> sfr_rdata[7:1] == 7'h01)
		else $error("flag register upper bits wrong");
	a_irq_needs_en: assert property (!receive_full_irq_enable_h [*2] |-> !rx_irq)
		else $error("irq without enable");
endmodule

//--- testbench/asr_remote_tx.sv
/*
  Remote asynchronous transmitter on the receive pin.
  Assumes the bench gives the bit time in clock cycles.
*/
module asr_remote_tx #(
	parameter int BIT_CYC = 32
) (
	// clock
	input wire logic sys_clk,
	// line
	output logic line
);
	timeunit 1ns;
	timeprecision 100ps;
	initial line = 1'b1;
	// a low stop is cut short so the false start it leaves is abandoned
	task automatic send(input logic [8:0] d, input int nb, input logic stop);
		for (int i = 0; i < nb + 2; i++) begin
			@(posedge sys_clk);
			#1 line = (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : stop;
			repeat ((i > nb && !stop) ? BIT_CYC * 3 / 4 - 1 : BIT_CYC - 1) @(posedge sys_clk);
		end
		@(posedge sys_clk);
		#1 line = 1'b1;
	endtask
endmodule

//--- testbench/asr_receiver_test.sv
/*
  Bench of the serial receiver: register tasks and frames from the remote model.
  Assumes divisor 1, so a bit is 32 cycles; the clock pin is driven for slave mode.
*/
module asr_receiver_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int BIT_CYC = 32;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_rdata;
	logic rx_irq;
	logic rx_line;
	logic pins;
	logic [7:0] v;
	logic ck_in = 1'b0;
	logic ck_out;
	logic ck_oe_n;
	logic ck_seen = 1'b0;
	int ck_rises = 0;
	int bad_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	always #4 sys_clk = ~sys_clk;
	asr_receiver i_asr_receiver (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.rx_irq(rx_irq), .serial_rx_data_pin(rx_line), .serial_tx_clock_pin_in(ck_in),
		.serial_tx_clock_pin_out(ck_out), .serial_tx_clock_pin_oe_n(ck_oe_n),
		.serial_pins_active(pins));
	// clock pin rises counted off the launching edge
	always @(negedge sys_clk) begin
		if (ck_out && !ck_seen)
			ck_rises++;
		ck_seen = ck_out;
	end
	asr_remote_tx #(.BIT_CYC(BIT_CYC)) i_asr_remote_tx (.sys_clk(sys_clk), .line(rx_line));
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input string w, input logic [7:0] seen, input logic [7:0] e);
		cmp_count++;
		if (seen !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", w, e, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#1 sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge sys_clk);
		#1 sfr_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		#1 sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge sys_clk);
		#1 sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask
	// bw and chk select the bank before each banked access
	task automatic bw(input logic [3:0] b, input logic [7:0] a, input logic [7:0] d);
		wr(8'h0f, {4'h0, b});
		wr(a, d);
	endtask
	task automatic chk(input logic [3:0] b, input logic [7:0] a, input logic [7:0] e);
		wr(8'h0f, {4'h0, b});
		rd(a, v);
		check($sformatf("reg %h bank %h", a, b), v, e);
	endtask
	task automatic rd_char(input logic [7:0] st, input logic [7:0] dt);
		chk(0, 8'h13, st);
		rd(8'h14, v);
		check("data", v, dt);
	endtask
	// external clock for slave mode, four cycles each level
	task automatic pulse_ck(input int n);
		repeat (n) begin
			step(4);
			ck_in = 1'b1;
			step(4);
			ck_in = 1'b0;
		end
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			give_verdict();
		end
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		#1 rst = 1'b0;
		chk(0, 8'h13, 8'h00);
		chk(0, 8'h15, 8'h02);
		chk(0, 8'h17, 8'h00);
		chk(1, 8'h16, 8'h02);
		chk(1, 8'h17, 8'h00);
		bw(0, 8'h15, 8'h00);
		bw(0, 8'h17, 8'h01);
		bw(0, 8'h13, 8'h90);
		step(2);
		check("pins", {7'h00, pins}, 8'h01);
		i_asr_remote_tx.send(9'h0a5, 8, 1'b1);
		step(2);
		chk(1, 8'h16, 8'h03);
		check("irq masked", {7'h00, rx_irq}, 8'h00);
		bw(1, 8'h17, 8'h01);
		step(2);
		check("irq", {7'h00, rx_irq}, 8'h01);
		rd_char(8'h90, 8'ha5);
		chk(1, 8'h16, 8'h02);
		i_asr_remote_tx.send(9'h03c, 8, 1'b0);
		step(2);
		rd_char(8'h94, 8'h3c);
		chk(0, 8'h13, 8'h90);
		bw(0, 8'h13, 8'hd0);
		i_asr_remote_tx.send(9'h1c3, 9, 1'b1);
		step(2);
		rd_char(8'hd1, 8'hc3);
		bw(0, 8'h13, 8'h90);
		chk(5, 8'h13, 8'h00);
		wr(8'h13, 8'h00);
		chk(0, 8'h13, 8'h90);
		for (int k = 0; k < 9; k++)
			i_asr_remote_tx.send({1'b0, 8'h10 + k[7:0]}, 8, 1'b1);
		step(2);
		chk(0, 8'h13, 8'h92);
		for (int k = 0; k < 8; k++) begin
			rd(8'h14, v);
			check("drain", v, 8'h10 + k[7:0]);
		end
		i_asr_remote_tx.send(9'h066, 8, 1'b1);
		step(2);
		chk(0, 8'h13, 8'h92);
		chk(1, 8'h16, 8'h02);
		bw(0, 8'h13, 8'ha0);
		chk(0, 8'h13, 8'ha0);
		i_asr_remote_tx.send(9'h055, 8, 1'b1);
		step(2);
		chk(1, 8'h16, 8'h02);
		bw(0, 8'h13, 8'h90);
		i_asr_remote_tx.send(9'h077, 8, 1'b1);
		step(2);
		rd_char(8'h90, 8'h77);
		// clocked master: one byte of idle-high data, then single receive drops
		bw(0, 8'h13, 8'h80);
		bw(0, 8'h15, 8'h90);
		bw(0, 8'h13, 8'ha0);
		step(300);
		check("clock oe_n", {7'h00, ck_oe_n}, 8'h00);
		check("clock rises", 8'(ck_rises), 8'h08);
		rd_char(8'h80, 8'hff);
		chk(1, 8'h16, 8'h02);
		// clocked slave ignores single receive, continuous takes eight edges
		bw(0, 8'h13, 8'h80);
		bw(0, 8'h15, 8'h10);
		bw(0, 8'h13, 8'ha0);
		pulse_ck(8);
		chk(1, 8'h16, 8'h02);
		check("clock released", {7'h00, ck_oe_n}, 8'h01);
		bw(0, 8'h13, 8'h90);
		pulse_ck(8);
		rd_char(8'h90, 8'hff);
		// port off: pins leave the serial function
		bw(0, 8'h13, 8'h00);
		step(2);
		check("pins off", {7'h00, pins}, 8'h00);
		give_verdict();
	end
endmodule
bind asr_receiver asr_receiver_props i_asr_receiver_props (.sys_clk(sys_clk), .rst(rst),
	.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
	.sfr_rdata(sfr_rdata), .rx_irq(rx_irq), .serial_rx_data_pin(serial_rx_data_pin),
	.serial_tx_clock_pin_in(serial_tx_clock_pin_in),
	.serial_tx_clock_pin_out(serial_tx_clock_pin_out),
	.serial_tx_clock_pin_oe_n(serial_tx_clock_pin_oe_n),
	.serial_pins_active(serial_pins_active));
